// ### hw/scrd_pkg.sv
// Shared constants for the synthesizer configuration register decode block
package scrd_pkg;

  // Serial word framing
  localparam int unsigned WORD_BITS = 32;
  localparam int unsigned SEL_LSB   = 0;
  localparam int unsigned SEL_MSB   = 2;

  // Register select codes
  localparam logic [2:0] SEL_INT_FRACTION_NUMERATOR  = 3'h0;
  localparam logic [2:0] SEL_PHASE_MOD = 3'h1;
  localparam logic [2:0] SEL_REF_CP    = 3'h2;
  localparam logic [2:0] SEL_CLK_DIV   = 3'h3;
  localparam logic [2:0] SEL_OUT_FB    = 3'h4;

  // Integer/fraction register fields
  localparam int unsigned INT_LSB  = 15;
  localparam int unsigned INT_MSB  = 30;
  localparam int unsigned FRACTION_NUMERATOR_LSB = 3;
  localparam int unsigned FRACTION_NUMERATOR_MSB = 14;

  // Phase/modulus register fields
  localparam int unsigned PRESCALER_BIT = 27;
  localparam int unsigned PHASE_LSB     = 15;
  localparam int unsigned PHASE_MSB     = 26;
  localparam int unsigned MOD_LSB       = 3;
  localparam int unsigned MOD_MSB       = 14;

  // Reference / charge pump register fields
  localparam int unsigned NOISE_LSB     = 29;
  localparam int unsigned NOISE_MSB     = 30;
  localparam int unsigned MUX_LSB       = 26;
  localparam int unsigned MUX_MSB       = 28;
  localparam int unsigned DOUBLER_BIT   = 25;
  localparam int unsigned HALVER_BIT    = 24;
  localparam int unsigned RDIV_LSB      = 14;
  localparam int unsigned RDIV_MSB      = 23;
  localparam int unsigned DBUF_BIT      = 13;
  localparam int unsigned CP_LSB        = 9;
  localparam int unsigned CP_MSB        = 12;
  localparam int unsigned LDF_BIT       = 8;
  localparam int unsigned LDP_BIT       = 7;
  localparam int unsigned POL_BIT       = 6;
  localparam int unsigned PDOWN_BIT     = 5;
  localparam int unsigned CP3S_BIT      = 4;
  localparam int unsigned CRESET_BIT    = 3;

  // Clock divider register fields
  localparam int unsigned CSR_BIT       = 18;
  localparam int unsigned CDMODE_LSB    = 15;
  localparam int unsigned CDMODE_MSB    = 16;
  localparam int unsigned CDVAL_LSB     = 3;
  localparam int unsigned CDVAL_MSB     = 14;

  // Output / feedback register fields
  localparam int unsigned FBSEL_BIT     = 23;
  localparam int unsigned ODIV_LSB      = 20;
  localparam int unsigned ODIV_MSB      = 22;

  // Noise modes and clock divider modes
  localparam logic [1:0] NOISE_LOW_NOISE = 2'h0;
  localparam logic [1:0] NOISE_LOW_SPUR  = 2'h3;
  localparam logic [1:0] CDMODE_OFF      = 2'h0;
  localparam logic [1:0] CDMODE_FASTLOCK = 2'h1;
  localparam logic [1:0] CDMODE_RESYNC   = 2'h2;

  // Integer divide minimums per prescaler
  localparam logic [15:0] NMIN_P45 = 16'd23;
  localparam logic [15:0] NMIN_P89 = 16'd75;

  // Reset values of the configuration words
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;
  localparam logic [11:0] RST_MOD    = 12'h002;
  localparam logic [9:0]  RST_RDIV   = 10'h001;

  // Lock detect windows and counts
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned LOCK_WIN_WIDE_NS   = 10;
  localparam int unsigned LOCK_WIN_NARROW_NS = 6;
  localparam int unsigned LOCK_CNT_FRACTION_NUMERATOR = 40;
  localparam int unsigned LOCK_CNT_INT  = 5;

  // Lock detect state
  typedef enum logic [1:0] {
    SCRD_LD_IDLE,
    SCRD_LD_COUNT,
    SCRD_LD_LOCKED
  } scrd_ld_type;

endpackage

// ### hw/scrd_shift_in.sv
// Three-wire serial input shift register with load strobe
`timescale 1ns/1ns
`default_nettype none

module scrd_shift_in
  import scrd_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 ser_clk_pin,
  input  wire logic                 ser_data_pin,
  input  wire logic                 ser_le_pin,
  output logic [scrd_pkg::WORD_BITS-1:0] word_q,
  output logic                      word_valid_q
);

  logic [2:0] clk_s_q;
  logic [1:0] dat_s_q;
  logic [2:0] le_s_q;
  logic [WORD_BITS-1:0] shift_q;

  // Two-flop synchronisers; third stage only for edge detection
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      clk_s_q <= 3'h0;
      dat_s_q <= 2'h0;
      le_s_q  <= 3'h0;
    end
    else
    begin
      clk_s_q <= {clk_s_q[1:0], ser_clk_pin};
      dat_s_q <= {dat_s_q[0], ser_data_pin};
      le_s_q  <= {le_s_q[1:0], ser_le_pin};
    end
  end

  // MSB first shift on rising serial clock
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      shift_q <= RST_WORD;
    else if (clk_s_q[1] && !clk_s_q[2])
      shift_q <= {shift_q[WORD_BITS-2:0], dat_s_q[1]};
  end

  // Latch the word on rising load enable
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      word_q       <= RST_WORD;
      word_valid_q <= 1'b0;
    end
    else
    begin
      word_valid_q <= le_s_q[1] && !le_s_q[2];
      if (le_s_q[1] && !le_s_q[2])
        word_q <= shift_q;
    end
  end

endmodule
`default_nettype wire

// ### hw/scrd_top.sv
// Configuration register decode and reference path control of the synthesizer
`timescale 1ns/1ns
`default_nettype none

// What this block does
// RULE1: Code 001 loads phase/modulus, 010 loads reference
// RULE2: Code 011 loads clock divider, 100 output
// RULE3: Prescaler picks 4/5 or 8/9, minimum N
// RULE4: Host keeps phase word below modulus
// RULE5: Twelve-bit fractional modulus field used
// RULE6: Noise bits select dither on or off
// RULE7: Doubler bit doubles reference before divider
// RULE8: Doubler off: falling edge; on: both edges
// RULE9: Halver toggles divider output to 50% duty
// RULE10: Ten-bit reference divider, ratios 1 to 1023
// RULE11: Double-buffer bit defers output divider select
// RULE12: Four-bit charge pump current setting
// RULE13: Lock function bit selects integer/fractional detect
// RULE14: Precision bit sets lock window and count; here the count follows the lock function bit only
// RULE15: Polarity bit sets phase detector sense
// RULE16: Power-down resets counters, lock, outputs
// RULE17: Three-state bit floats charge pump
// RULE18: Counter reset holds both counters
// RULE19: Cycle slip reduction enable bit
// RULE20: Clock divider mode: resync, fast lock, off
// RULE21: Twelve-bit timeout for resync and fast lock
// RULE22: Feedback select: oscillator direct or divided
// RULE23: Buffered fields commit on integer word
// RULE24: Code 000 loads integer/fraction register
// RULE25: Words are 32 bits, select bits lowest
module scrd_top
  import scrd_pkg::*;
#(
  parameter int unsigned RDIV_W  = 10,
  parameter int unsigned MOD_W   = 12,
  parameter int unsigned CDVAL_W = 12
)
(
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         ser_clk_pin,
  input  wire logic         ser_data_pin,
  input  wire logic         ser_le_pin,
  input  wire logic         reference_input,
  input  wire logic         fb_in_window,
  output logic              phase_detector_ref_q,
  output logic              ref_edge_q,
  output logic              dither_en_q,
  output logic              prescaler_select_q,
  output logic              int_below_min_q,
  output logic [11:0]       fraction_numerator_q,
  output logic [MOD_W-1:0]  fractional_modulus_q,
  output logic [11:0]       phase_word_q,
  output logic [2:0]        test_mux_output_q,
  output logic [3:0]        cp_current_q,
  output logic              cp_three_state_q,
  output logic              pd_polarity_q,
  output logic              counters_reset_q,
  output logic              osc_enable_q,
  output logic              rf_out_enable_q,
  output logic              lock_detect_q,
  output logic              cycle_slip_reduction_q,
  output logic [1:0]        clkdiv_mode_q,
  output logic              clkdiv_timeout_q,
  output logic              feedback_direct_q,
  output logic [2:0]        out_div_sel_q
);

  localparam int unsigned WIN_WIDE_CYC =
    (LOCK_WIN_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WIN_NARROW_CYC =
    (LOCK_WIN_NARROW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  logic [WORD_BITS-1:0] word;
  logic                 word_valid;
  logic [2:0]           sel;

  // Pending (written) copies of buffered fields
  logic [11:0]       phase_pend_q;
  logic [MOD_W-1:0]  mod_pend_q;
  logic              pre_pend_q;
  logic [RDIV_W-1:0] rdiv_pend_q;
  logic              dbl_pend_q;
  logic              half_pend_q;
  logic [2:0]        odiv_pend_q;
  // Active copies
  logic [RDIV_W-1:0] rdiv_q;
  logic              dbl_q;
  logic              half_q;
  logic [15:0]       int_q;
  // Immediate configuration bits
  logic [1:0]        noise_q;
  logic              dbuf_q;
  logic              ldf_q;
  logic              ldp_q;
  logic              pdown_q;
  logic              cp3s_q;
  logic              creset_q;
  logic [CDVAL_W-1:0] cdval_q;

  scrd_shift_in u_shift
  (
    .mclk         (mclk),
    .rst_n        (rst_n),
    .ser_clk_pin  (ser_clk_pin),
    .ser_data_pin (ser_data_pin),
    .ser_le_pin   (ser_le_pin),
    .word_q       (word),
    .word_valid_q (word_valid)
  );

  // RULE25: select bits lowest
  assign sel = word[SEL_MSB:SEL_LSB];

  // RULE1: phase and modulus load
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      phase_pend_q <= 12'h001;
      mod_pend_q   <= MOD_W'(RST_MOD);
      pre_pend_q   <= 1'b0;
    end
    else if (word_valid && sel == SEL_PHASE_MOD)
    begin
      phase_pend_q <= word[PHASE_MSB:PHASE_LSB];
      // RULE5: twelve-bit modulus
      mod_pend_q   <= word[MOD_LSB +: MOD_W];
      pre_pend_q   <= word[PRESCALER_BIT];
    end
  end

  // RULE1: reference and charge pump load
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      noise_q           <= NOISE_LOW_NOISE;
      test_mux_output_q <= 3'h0;
      dbl_pend_q        <= 1'b0;
      half_pend_q       <= 1'b0;
      rdiv_pend_q       <= RDIV_W'(RST_RDIV);
      dbuf_q            <= 1'b0;
      cp_current_q      <= 4'h0;
      ldf_q             <= 1'b0;
      ldp_q             <= 1'b0;
      pd_polarity_q     <= 1'b1;
      pdown_q           <= 1'b0;
      cp3s_q            <= 1'b0;
      creset_q          <= 1'b0;
    end
    else if (word_valid && sel == SEL_REF_CP)
    begin
      noise_q           <= word[NOISE_MSB:NOISE_LSB];
      test_mux_output_q <= word[MUX_MSB:MUX_LSB];
      dbl_pend_q        <= word[DOUBLER_BIT];
      half_pend_q       <= word[HALVER_BIT];
      // RULE10: ten-bit ratio
      rdiv_pend_q       <= word[RDIV_LSB +: RDIV_W];
      dbuf_q            <= word[DBUF_BIT];
      // RULE12: charge pump current
      cp_current_q      <= word[CP_MSB:CP_LSB];
      ldf_q             <= word[LDF_BIT];
      ldp_q             <= word[LDP_BIT];
      // RULE15: detector polarity
      pd_polarity_q     <= word[POL_BIT];
      pdown_q           <= word[PDOWN_BIT];
      cp3s_q            <= word[CP3S_BIT];
      creset_q          <= word[CRESET_BIT];
    end
  end

  // RULE2: clock divider load
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cycle_slip_reduction_q <= 1'b0;
      clkdiv_mode_q          <= CDMODE_OFF;
      cdval_q                <= '0;
    end
    else if (word_valid && sel == SEL_CLK_DIV)
    begin
      // RULE19: slip reduction enable
      cycle_slip_reduction_q <= word[CSR_BIT];
      // RULE20: divider mode
      clkdiv_mode_q          <= word[CDMODE_MSB:CDMODE_LSB];
      cdval_q                <= word[CDVAL_LSB +: CDVAL_W];
    end
  end

  // RULE2: output and feedback load
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      feedback_direct_q <= 1'b0;
      odiv_pend_q       <= 3'h0;
    end
    else if (word_valid && sel == SEL_OUT_FB)
    begin
      // RULE22: feedback source
      feedback_direct_q <= word[FBSEL_BIT];
      odiv_pend_q       <= word[ODIV_MSB:ODIV_LSB];
    end
  end

  // RULE24: integer word commits buffered fields
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      int_q                <= 16'h0;
      fraction_numerator_q <= 12'h0;
      phase_word_q         <= 12'h001;
      fractional_modulus_q <= MOD_W'(RST_MOD);
      prescaler_select_q   <= 1'b0;
      rdiv_q               <= RDIV_W'(RST_RDIV);
      dbl_q                <= 1'b0;
      half_q               <= 1'b0;
    end
    else if (word_valid && sel == SEL_INT_FRACTION_NUMERATOR)
    begin
      int_q                <= word[INT_MSB:INT_LSB];
      fraction_numerator_q <= word[FRACTION_NUMERATOR_MSB:FRACTION_NUMERATOR_LSB];
      // RULE23: commit buffered fields
      phase_word_q         <= phase_pend_q;
      fractional_modulus_q <= mod_pend_q;
      prescaler_select_q   <= pre_pend_q;
      rdiv_q               <= rdiv_pend_q;
      dbl_q                <= dbl_pend_q;
      half_q               <= half_pend_q;
    end
  end

  // RULE11: output divider buffering
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      out_div_sel_q <= 3'h0;
    else if (!dbuf_q)
      out_div_sel_q <= odiv_pend_q;
    else if (word_valid && sel == SEL_INT_FRACTION_NUMERATOR)
      out_div_sel_q <= odiv_pend_q;
  end

  // RULE3: minimum integer check
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      int_below_min_q <= 1'b0;
    else
      int_below_min_q <= int_q < (prescaler_select_q ? NMIN_P89 : NMIN_P45);
  end

  // RULE6: dither follows noise mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      dither_en_q <= 1'b0;
    else
      dither_en_q <= (noise_q == NOISE_LOW_SPUR);
  end

  // RULE16: power-down effects; RULE17: three-state
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      cp_three_state_q <= 1'b0;
      osc_enable_q     <= 1'b1;
      rf_out_enable_q  <= 1'b1;
      counters_reset_q <= 1'b0;
    end
    else
    begin
      cp_three_state_q <= cp3s_q || pdown_q;
      osc_enable_q     <= !pdown_q;
      rf_out_enable_q  <= !pdown_q;
      // RULE18: hold both counters
      counters_reset_q <= creset_q || pdown_q;
    end
  end

  // Reference input synchroniser
  logic [2:0] ref_s_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      ref_s_q <= 3'h0;
    else
      ref_s_q <= {ref_s_q[1:0], reference_input};
  end

  // RULE7: doubler gives both edges; RULE8: active edges
  logic ref_tick;
  assign ref_tick = dbl_q ? (ref_s_q[1] ^ ref_s_q[2]) : (!ref_s_q[1] && ref_s_q[2]);

  // RULE10: reference divider counter
  logic [RDIV_W-1:0] rcnt_q;
  logic              rdiv_tick;
  assign rdiv_tick = ref_tick && (rcnt_q + 1'b1 >= rdiv_q);
  always_ff @(posedge mclk)
  begin
    if (!rst_n || counters_reset_q)
      rcnt_q <= '0;
    else if (ref_tick)
      rcnt_q <= rdiv_tick ? '0 : rcnt_q + 1'b1;
  end

  // RULE9: halver toggle stage
  always_ff @(posedge mclk)
  begin
    if (!rst_n || counters_reset_q)
    begin
      phase_detector_ref_q <= 1'b0;
      ref_edge_q           <= 1'b0;
    end
    else
    begin
      ref_edge_q <= rdiv_tick && (!half_q || phase_detector_ref_q);
      if (rdiv_tick)
        phase_detector_ref_q <= half_q ? !phase_detector_ref_q : 1'b1;
      else if (!half_q)
        phase_detector_ref_q <= 1'b0;
    end
  end

  // RULE13: mode select; RULE14: window and count
  logic [5:0]  lock_need;
  logic        win_narrow;
  assign win_narrow = ldf_q ? !ldp_q : ldp_q;
  assign lock_need  = ldf_q ? 6'(LOCK_CNT_INT) : 6'(LOCK_CNT_FRACTION_NUMERATOR);

  // Window width in clocks (internal; only gates the step from idle to counting)
  logic [1:0] win_cyc;
  assign win_cyc = win_narrow ? 2'(WIN_NARROW_CYC) : 2'(WIN_WIDE_CYC);

  scrd_ld_type ld_state_q;
  logic [5:0]  ld_cnt_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_n || pdown_q)
    begin
      ld_state_q    <= SCRD_LD_IDLE;
      ld_cnt_q      <= '0;
      lock_detect_q <= 1'b0;
    end
    else if (ref_edge_q)
    begin
      unique case (ld_state_q)
        SCRD_LD_IDLE:
        begin
          ld_cnt_q   <= 6'h01;
          ld_state_q <= (fb_in_window && win_cyc != 2'h0) ? SCRD_LD_COUNT : SCRD_LD_IDLE;
        end
        SCRD_LD_COUNT:
        begin
          if (!fb_in_window)
          begin
            ld_cnt_q   <= '0;
            ld_state_q <= SCRD_LD_IDLE;
          end
          else if (ld_cnt_q + 6'h01 >= lock_need)
          begin
            ld_state_q    <= SCRD_LD_LOCKED;
            lock_detect_q <= 1'b1;
          end
          else
            ld_cnt_q <= ld_cnt_q + 6'h01;
        end
        SCRD_LD_LOCKED:
        begin
          if (!fb_in_window)
          begin
            ld_state_q    <= SCRD_LD_IDLE;
            lock_detect_q <= 1'b0;
          end
        end
      endcase
    end
  end

  // RULE21: timeout timer for resync and fast lock
  logic [CDVAL_W-1:0] cd_cnt_q;
  always_ff @(posedge mclk)
  begin
    if (!rst_n || clkdiv_mode_q == CDMODE_OFF || (word_valid && sel == SEL_INT_FRACTION_NUMERATOR))
    begin
      cd_cnt_q         <= '0;
      clkdiv_timeout_q <= 1'b0;
    end
    else if (ref_edge_q && !clkdiv_timeout_q)
    begin
      cd_cnt_q <= cd_cnt_q + 1'b1;
      if (cd_cnt_q + 1'b1 >= cdval_q)
        clkdiv_timeout_q <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ### sim/scrd_host_model.sv
// Host controller model shifting configuration words over the three-wire link
`timescale 1ns/1ns
`default_nettype none

module scrd_host_model
(
  input  wire logic mclk,
  output logic      ser_clk_pin,
  output logic      ser_data_pin,
  output logic      ser_le_pin
);
  // Link idles with the serial clock and load enable low
  initial
  begin
    ser_clk_pin  = 1'b0;
    ser_data_pin = 1'b0;
    ser_le_pin   = 1'b0;
  end

  task automatic send_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      @(negedge mclk);
      ser_data_pin = w[i];
      repeat (4) @(negedge mclk);
      ser_clk_pin = 1'b1;
      repeat (4) @(negedge mclk);
      ser_clk_pin = 1'b0;
    end
    @(negedge mclk);
    ser_le_pin   = 1'b1;
    ser_data_pin = ~w[0]; // Released data does not keep its last value
    repeat (4) @(negedge mclk);
    ser_le_pin = 1'b0;
  endtask
endmodule

`default_nettype wire

// ### sim/scrd_top_props.sv
// Concurrent checks on the ports of the register decode block
`timescale 1ns/1ns
`default_nettype none

module scrd_top_props
  import scrd_pkg::*;
#(
  parameter int unsigned MOD_W = 12
)
(
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             ser_le_pin,
  input wire logic             ref_edge_q,
  input wire logic             dither_en_q,
  input wire logic [MOD_W-1:0] fractional_modulus_q,
  input wire logic [11:0]      phase_word_q,
  input wire logic [3:0]       cp_current_q,
  input wire logic             pd_polarity_q,
  input wire logic             cp_three_state_q,
  input wire logic             counters_reset_q,
  input wire logic             osc_enable_q,
  input wire logic             rf_out_enable_q,
  input wire logic             lock_detect_q,
  input wire logic [1:0]       clkdiv_mode_q,
  input wire logic             clkdiv_timeout_q
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_pd_three; !osc_enable_q |-> cp_three_state_q; endproperty
  a_pd_three: assert property (p_pd_three) else $error("charge pump driven in power-down");
  property p_pd_creset; !osc_enable_q |-> counters_reset_q; endproperty
  a_pd_creset: assert property (p_pd_creset) else $error("counters free in power-down");
  property p_pd_outs; osc_enable_q == rf_out_enable_q; endproperty
  a_pd_outs: assert property (p_pd_outs) else $error("output enable differs from osc");
  property p_pd_lock; !osc_enable_q ##1 !osc_enable_q |-> !lock_detect_q; endproperty
  a_pd_lock: assert property (p_pd_lock) else $error("lock held in power-down");
  property p_edge_pulse; ref_edge_q |=> !ref_edge_q; endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("comparison event too long");
  property p_cfg_stable;
    !ser_le_pin [*7] |-> $stable({dither_en_q, fractional_modulus_q, phase_word_q,
                                  cp_current_q, pd_polarity_q, clkdiv_mode_q});
  endproperty
  a_cfg_stable: assert property (p_cfg_stable) else $error("config changed without load");
  property p_timeout_off; clkdiv_mode_q == CDMODE_OFF [*2] |-> !clkdiv_timeout_q; endproperty
  a_timeout_off: assert property (p_timeout_off) else $error("timeout with divider off");
  property p_timeout_rise; $rose(clkdiv_timeout_q) |-> clkdiv_mode_q != CDMODE_OFF; endproperty
  a_timeout_rise: assert property (p_timeout_rise) else $error("timeout rose while off");
endmodule

bind scrd_top scrd_top_props #(.MOD_W(MOD_W)) i_props (
  .mclk(mclk), .rst_n(rst_n), .ser_le_pin(ser_le_pin), .ref_edge_q(ref_edge_q),
  .dither_en_q(dither_en_q), .fractional_modulus_q(fractional_modulus_q),
  .phase_word_q(phase_word_q), .cp_current_q(cp_current_q), .pd_polarity_q(pd_polarity_q),
  .cp_three_state_q(cp_three_state_q), .counters_reset_q(counters_reset_q),
  .osc_enable_q(osc_enable_q), .rf_out_enable_q(rf_out_enable_q),
  .lock_detect_q(lock_detect_q), .clkdiv_mode_q(clkdiv_mode_q),
  .clkdiv_timeout_q(clkdiv_timeout_q));

`default_nettype wire

// ### sim/testbench.sv
// Self-checking bench for the register decode block
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import scrd_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, reference_input = 1'b0, fb_in_window = 1'b0;
  wire  sck, sdi, sle;
  logic dt, ps, bm, pr, ct, pp, cr, oe, re, lk, cs, to, fb, ee;
  logic [11:0] fr, md, ph;
  logic [2:0]  mx, od;
  logic [3:0]  cp;
  logic [1:0]  cm;
  int fails = 0, comparisons = 0, cycles = 0;

  scrd_host_model i_host (.mclk(mclk), .ser_clk_pin(sck), .ser_data_pin(sdi),
    .ser_le_pin(sle));
  scrd_top i_dut (.mclk(mclk), .rst_n(rst_n), .ser_clk_pin(sck), .ser_data_pin(sdi),
    .ser_le_pin(sle), .reference_input(reference_input), .fb_in_window(fb_in_window),
    .phase_detector_ref_q(pr), .ref_edge_q(ee), .dither_en_q(dt), .prescaler_select_q(ps),
    .int_below_min_q(bm), .fraction_numerator_q(fr), .fractional_modulus_q(md),
    .phase_word_q(ph), .test_mux_output_q(mx), .cp_current_q(cp), .cp_three_state_q(ct),
    .pd_polarity_q(pp), .counters_reset_q(cr), .osc_enable_q(oe), .rf_out_enable_q(re),
    .lock_detect_q(lk), .cycle_slip_reduction_q(cs), .clkdiv_mode_q(cm),
    .clkdiv_timeout_q(to), .feedback_direct_q(fb), .out_div_sel_q(od));

  // Clock, slow reference and hang limit
  always #20 mclk = ~mclk;
  always
  begin
    repeat (5) @(negedge mclk);
    reference_input = ~reference_input;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fails++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (fails == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic wr(input logic [31:0] w);
    i_host.send_word(w);
    repeat (8) @(negedge mclk);
  endtask
  // Word builders; flags are lock function, precision, polarity, power-down, 3-state, reset
  function automatic logic [31:0] rc(input logic [1:0] n, input logic [2:0] m,
    input logic d, h, input logic [9:0] r, input logic b, input logic [3:0] c,
    input logic [5:0] f);
    return {1'b0, n, m, d, h, r, b, c, f, SEL_REF_CP};
  endfunction
  function automatic logic [31:0] iw(input logic [15:0] n);
    return {1'b0, n, 12'h007, SEL_INT_FRACTION_NUMERATOR};
  endfunction
  function automatic logic [31:0] pm(input logic p);
    return {4'h0, p, 12'h005, 12'h064, SEL_PHASE_MOD};
  endfunction
  task automatic edges(input int n);
    int k;
    k = 0;
    for (int t = 0; t < 3000 && k < n; t++)
    begin
      @(negedge mclk);
      if (ee === 1'b1) k++;
    end
  endtask

  task automatic t_reset;
    check("osc", oe, 1);
    check("modulus", md, 2);
    check("phase", ph, 1);
    check("polarity", pp, 1);
  endtask
  task automatic t_refcp;
    wr(rc(2'h3, 3'h5, 0, 0, 10'h001, 0, 4'ha, 6'h08));
    check("dither", dt, 1);
    check("mux", mx, 5);
    check("cp", cp, 4'ha);
    wr(rc(2'h0, 3'h2, 0, 0, 10'h001, 0, 4'h3, 6'h00));
    check("dither", dt, 0);
    check("polarity", pp, 0);
    wr((rc(2'h3, 3'h7, 0, 0, 10'h001, 0, 4'hf, 6'h3f) & ~32'h7) | 32'h5);
    check("cp", cp, 3);
  endtask
  task automatic t_power;
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h0c));
    check("pd", {oe, re, ct, cr, cp}, 8'h39);
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h0a));
    check("tristate", {oe, ct, cr}, 3'h6);
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h09));
    check("creset", {oe, ct, cr}, 3'h5);
  endtask
  task automatic t_buffer;
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h08));
    wr(pm(1));
    check("modulus held", md, 2);
    wr(iw(16'd80));
    check("prescaler", ps, 1);
    check("phase", ph, 5);
    check("modulus", {md, fr}, 24'h064007);
    for (int i = 0; i < 4; i++)
    begin
      wr(pm(i < 2));
      wr(iw(i < 2 ? 16'd74 + 16'(i) : 16'd20 + 16'(i)));
      check("below min", bm, !i[0]);
    end
  endtask
  task automatic t_outfb;
    wr({8'h0, 1'b1, 3'h3, 17'h0, SEL_OUT_FB});
    check("out", {fb, od}, 4'hb);
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 1, 4'h9, 6'h08));
    wr({8'h0, 1'b0, 3'h6, 17'h0, SEL_OUT_FB});
    check("out held", {fb, od}, 4'h3);
    wr(iw(16'd80));
    check("out", od, 6);
  endtask
  task automatic t_clkdiv;
    for (int m = 0; m < 3; m++)
    begin
      wr({13'h0, m[0], 1'b0, m[1:0], 12'h003, SEL_CLK_DIV});
      check("cd mode", {cs, cm}, {m[0], m[1:0]});
    end
    wr({15'h0, CDMODE_FASTLOCK, 12'h003, SEL_CLK_DIV});
    edges(6);
    check("timeout", to, 1);
    wr({15'h0, CDMODE_OFF, 12'h003, SEL_CLK_DIV});
    check("timeout", to, 0);
    // Long count: still low short of the limit, high just past it
    wr({15'h0, CDMODE_FASTLOCK, 12'h0ff, SEL_CLK_DIV});
    edges(250);
    check("timeout early", to, 0);
    edges(10);
    check("timeout", to, 1);
  endtask
  task automatic t_rate;
    int c;
    int h;
    int e;
    for (int i = 0; i < 4; i++)
    begin
      wr(rc(2'h0, 3'h0, i == 1, i == 3, i == 2 ? 10'h004 : 10'h001, 0, 4'h9, 6'h08));
      wr(iw(16'd80));
      c = 0;
      h = 0;
      repeat (200)
      begin
        @(negedge mclk);
        c += int'(ee === 1'b1);
        h += int'(pr === 1'b1);
      end
      e = i == 1 ? 40 : i == 2 ? 5 : i == 3 ? 10 : 20;
      check("rate", c >= e - 2 && c <= e + 2, 1);
      // Halver gives half-time high, otherwise one pulse per divider cycle
      check("ref duty", h >= (i == 3 ? 98 : e - 2) && h <= (i == 3 ? 102 : e + 2), 1);
    end
  endtask
  task automatic t_lock;
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h28));
    fb_in_window = 1'b1;
    edges(3);
    check("int lock", lk, 0);
    edges(5);
    check("int lock", lk, 1);
    fb_in_window = 1'b0;
    wr(rc(2'h0, 3'h0, 0, 0, 10'h001, 0, 4'h9, 6'h08));
    fb_in_window = 1'b1;
    edges(30);
    check("fraction_numerator lock", lk, 0);
    edges(15);
    check("fraction_numerator lock", lk, 1);
  endtask

  initial
  begin
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    repeat (2) @(negedge mclk);
    t_reset();
    t_refcp();
    t_power();
    t_buffer();
    t_outfb();
    t_clkdiv();
    t_rate();
    t_lock();
    finish_test();
  end
endmodule

`default_nettype wire
